// *** inc/epel_pkg.sv ***
// package of constants for the energy pulse event latch
package epel_pkg;
	// ****************************************************************
	// clocking and timing
	// ****************************************************************
	localparam int unsigned SYS_CLK_HZ = 250000000; // system clock rate
	localparam int unsigned ACC_RATE_HZ = 1000000; // converter accumulation rate, 1 MHz
	localparam int unsigned TICK_CYC = SYS_CLK_HZ / ACC_RATE_HZ; // cycles per accumulation tick
	localparam int unsigned PULSE_LOW_CYC = 4; // low time of a converter output, cycles
	localparam int unsigned PWR_SHIFT = 7; // left shift applied to powers in the converter

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int unsigned SEL_LSB = 0; // power select fields, 3 bits per output
	localparam int unsigned DIS_LSB = 9; // output disable bits [11:9]
	localparam int unsigned LATCH_LSB = 12; // latch enable bits [14:12]
	localparam int unsigned CF_IRQ_LSB = 14; // pulse status bits [16:14]
	localparam int unsigned REV1_BIT = 9; // sign change status, first output
	localparam int unsigned REV2_BIT = 13; // sign change status, second output
	localparam int unsigned REV3_BIT = 18; // sign change status, third output
	localparam int unsigned SGN1_BIT = 3; // sum polarity, first output
	localparam int unsigned SGN2_BIT = 7; // sum polarity, second output
	localparam int unsigned SGN3_BIT = 8; // sum polarity, third output
	localparam int unsigned ACT_ACC_LSB = 0; // active accumulation field [1:0]
	localparam int unsigned REA_ACC_LSB = 2; // reactive accumulation field [3:2]

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [31:0] STATUS_RST = 32'h0000_0000; // status after reset
	localparam logic [15:0] SIGN_RST = 16'h0000; // polarity flags after reset
	localparam logic [7:0] CNT_RST = 8'h00; // latch edge counter after reset

	// ****************************************************************
	// power select and accumulation codes
	// ****************************************************************
	typedef enum logic [2:0]
	{
		EPEL_SEL_ACT = 3'h0, // total active
		EPEL_SEL_REA = 3'h1, // total reactive
		EPEL_SEL_APP = 3'h2, // apparent
		EPEL_SEL_FACT = 3'h3, // fundamental active
		EPEL_SEL_FREA = 3'h4 // fundamental reactive
	} epel_sel_t;
	localparam logic [1:0] ACC_SIGNED = 2'h0; // signed accumulation
	localparam logic [1:0] ACC_SIGNADJ = 2'h2; // reactive sign adjusted by active sign
	localparam logic [1:0] ACC_ABS = 2'h3; // absolute accumulation
endpackage : epel_pkg

// *** rtl/epel_top.sv ***
// pulse converter event, latch and sign logic for three outputs
// Contract
// - masked falling edge sets pulse status, interrupt
// - pulse interrupt works with output disabled
// - latch copies selected type energies, then clears
// - all three phases latched regardless of inclusion
// - eight-bit count sets edges between latches
// - latch enable bits gate latching, default off
// - latching works with output disabled
// - active field governs active selects, 00 signed
// - active code 11 accumulates absolute power
// - active codes 01, 10 act as signed
// - reactive field governs reactive selects, 00 signed
// - reactive code 10 follows active power sign
// - reactive code 11 accumulates absolute power
// - reactive code 01 acts as signed
// - sign checked only at threshold crossing
// - sign change status set with falling edge
// - polarity flags update with change status
// - masked sign change raises interrupt, sets status
// - write one clears status, releases interrupt
// - three-bit select picks power type
// - accumulate shifted powers at 1 MHz, subtract threshold
// - disable bit holds pin high, else pulses
`timescale 1ns/10ps
module epel_top
	import epel_pkg::*;
#(
	parameter int unsigned PWR_W = 24, // width of a phase power sample
	parameter int unsigned THR_W = 32, // width of an energy threshold
	parameter int unsigned ENE_W = 32 // width of an energy register
)
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic signed [PWR_W-1:0] phase_power [5][3],
	input wire logic [THR_W-1:0] active_energy_threshold,
	input wire logic [THR_W-1:0] reactive_energy_threshold,
	input wire logic [THR_W-1:0] apparent_energy_threshold,
	input wire logic [15:0] pulse_output_mode_reg,
	input wire logic [7:0] accumulation_mode_reg,
	input wire logic [8:0] computation_mode_reg,
	input wire logic [31:0] irq_mask_primary,
	input wire logic [7:0] latch_pulse_count,
	input wire logic status_clear_wr,
	input wire logic [31:0] status_clear_data,
	output logic [31:0] irq_status_primary,
	output logic [15:0] power_sign_flags,
	output logic interrupt_line_primary,
	output logic pulse_out_one,
	output logic pulse_out_two,
	output logic pulse_out_three,
	output logic signed [ENE_W-1:0] energy_hours [5][3]
);
	localparam int unsigned ACC_W = THR_W + PWR_SHIFT + 2; // converter accumulator width
	localparam int unsigned TICK_W = $clog2(TICK_CYC); // tick counter width
	localparam int unsigned LOW_W = $clog2(PULSE_LOW_CYC + 1); // low time counter width

	// ****************************************************************
	// accumulation tick
	// ****************************************************************
	logic [TICK_W-1:0] tick_cnt_reg; // divides the system clock to the tick rate
	logic tick; // one cycle per microsecond

	assign tick = (tick_cnt_reg == TICK_W'(TICK_CYC - 1));

	// free running tick divider
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			tick_cnt_reg <= '0;
		else if (tick)
			tick_cnt_reg <= '0;
		else
			tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
	end

	// ****************************************************************
	// converter input conditioning
	// ****************************************************************
	// apply the accumulation mode to one phase's power for one converter
	function automatic logic signed [PWR_W:0] cond_power(
		input logic [2:0] sel,
		input logic [1:0] act_mode,
		input logic [1:0] rea_mode,
		input logic signed [PWR_W-1:0] pwr,
		input logic signed [PWR_W-1:0] act_pwr
	);
		logic signed [PWR_W:0] p;
		logic signed [PWR_W:0] neg;
		p = {pwr[PWR_W-1], pwr};
		neg = -p;
		cond_power = p;
		unique case (sel)
			EPEL_SEL_ACT, EPEL_SEL_FACT:
			begin
				// codes 00, 01, 10 stay signed
				if (act_mode == ACC_ABS && p < 0)
					cond_power = neg;
			end
			EPEL_SEL_REA, EPEL_SEL_FREA:
			begin
				// code 01 stays signed
				if (rea_mode == ACC_ABS && p < 0)
					cond_power = neg;
				else if (rea_mode == ACC_SIGNADJ && act_pwr < 0)
					cond_power = neg;
			end
			EPEL_SEL_APP:
				cond_power = p;
			default:
				cond_power = '0; // reserved select adds nothing
		endcase
	endfunction : cond_power

	// ****************************************************************
	// per output converter, pulse, latch counter and sign tracker
	// ****************************************************************
	logic [2:0] ch_edge; // falling edge of each converter output
	logic [2:0] ch_change; // sign change reported with that edge
	logic [2:0] ch_neg; // sum sign captured at the edge
	logic [2:0] ch_latch; // latch request from each output
	logic [2:0] ch_level; // converter output level before disable
	logic [2:0] ch_sel [3]; // power select of each output
	logic [7:0] cyc_eff; // count with zero treated as one

	assign cyc_eff = (latch_pulse_count == 8'h00) ? 8'h01 : latch_pulse_count;

	genvar c;
	generate
		for (c = 0; c < 3; c++)
		begin : g_ch
			logic signed [ACC_W-1:0] acc_reg; // first stage accumulator
			logic signed [ACC_W-1:0] acc_next; // accumulator after this tick
			logic signed [ACC_W-1:0] thr; // threshold shifted left
			logic signed [ACC_W-1:0] sum; // conditioned sum of included phases
			logic [THR_W-1:0] thr_raw; // threshold of the selected type
			logic [2:0] incl; // phase inclusion for this output
			logic fire_pos; // threshold reached upward
			logic fire_neg; // threshold reached downward
			logic [LOW_W-1:0] low_cnt_reg; // remaining low cycles
			logic [7:0] edge_cnt_reg; // edges since last latch
			logic last_neg_reg; // sign at the previous crossing

			assign ch_sel[c] = pulse_output_mode_reg[SEL_LSB+3*c +: 3];
			assign incl = computation_mode_reg[3*c +: 3];

			// pick the threshold and add the included phases
			always_comb
			begin
				unique case (ch_sel[c])
					EPEL_SEL_ACT, EPEL_SEL_FACT:
						thr_raw = active_energy_threshold;
					EPEL_SEL_REA, EPEL_SEL_FREA:
						thr_raw = reactive_energy_threshold;
					EPEL_SEL_APP:
						thr_raw = apparent_energy_threshold;
					default:
						thr_raw = '0;
				endcase
				thr = ACC_W'(thr_raw) <<< PWR_SHIFT;
				sum = '0;
				for (int ph = 0; ph < 3; ph++)
				begin
					if (incl[ph] && ch_sel[c] <= EPEL_SEL_FREA)
						sum = sum + ACC_W'(cond_power(ch_sel[c],
							accumulation_mode_reg[ACT_ACC_LSB +: 2],
							accumulation_mode_reg[REA_ACC_LSB +: 2],
							phase_power[ch_sel[c]][ph],
							phase_power[(ch_sel[c] == EPEL_SEL_FREA) ? 3 : 0][ph]));
				end
				acc_next = acc_reg + (sum <<< PWR_SHIFT);
				fire_pos = tick && (thr != 0) && (acc_next >= thr);
				fire_neg = tick && (thr != 0) && (acc_next <= -thr);
			end

			// first stage accumulation with threshold subtraction
			always_ff @(posedge sys_clk or negedge resetn)
			begin
				if (!resetn)
					acc_reg <= '0;
				else if (fire_pos)
					acc_reg <= acc_next - thr;
				else if (fire_neg)
					acc_reg <= acc_next + thr;
				else if (tick)
					acc_reg <= acc_next;
			end

			assign ch_edge[c] = fire_pos | fire_neg;
			assign ch_neg[c] = fire_neg; // sign taken only at the crossing
			assign ch_change[c] = ch_edge[c] && (fire_neg != last_neg_reg);
			assign ch_level[c] = (low_cnt_reg == '0);

			// sign seen at the previous crossing
			always_ff @(posedge sys_clk or negedge resetn)
			begin
				if (!resetn)
					last_neg_reg <= 1'b0;
				else if (ch_edge[c])
					last_neg_reg <= fire_neg;
			end

			// output low time after each crossing
			always_ff @(posedge sys_clk or negedge resetn)
			begin
				if (!resetn)
					low_cnt_reg <= '0;
				else if (ch_edge[c])
					low_cnt_reg <= LOW_W'(PULSE_LOW_CYC);
				else if (low_cnt_reg != '0)
					low_cnt_reg <= low_cnt_reg - LOW_W'(1);
			end

			// edges between latches, independent of the disable bit
			always_ff @(posedge sys_clk or negedge resetn)
			begin
				if (!resetn)
					edge_cnt_reg <= CNT_RST;
				else if (!pulse_output_mode_reg[LATCH_LSB+c])
					edge_cnt_reg <= CNT_RST;
				else if (ch_edge[c])
				begin
					if (edge_cnt_reg + 8'h01 >= cyc_eff)
						edge_cnt_reg <= CNT_RST;
					else
						edge_cnt_reg <= edge_cnt_reg + 8'h01;
				end
			end

			assign ch_latch[c] = ch_edge[c] && pulse_output_mode_reg[LATCH_LSB+c]
				&& (edge_cnt_reg + 8'h01 >= cyc_eff);
		end
	endgenerate

	// output pins, held high while disabled
	assign pulse_out_one = pulse_output_mode_reg[DIS_LSB] | ch_level[0];
	assign pulse_out_two = pulse_output_mode_reg[DIS_LSB+1] | ch_level[1];
	assign pulse_out_three = pulse_output_mode_reg[DIS_LSB+2] | ch_level[2];

	// ****************************************************************
	// phase energy accumulators and hour registers
	// ****************************************************************
	logic [4:0] type_latch; // latch request per power type
	logic signed [ENE_W-1:0] energy_acc_reg [5][3]; // internal signed energies

	// any enabled output whose select names the type latches it
	always_comb
	begin
		type_latch = '0;
		for (int k = 0; k < 3; k++)
		begin
			if (ch_latch[k] && ch_sel[k] <= EPEL_SEL_FREA)
				type_latch[ch_sel[k]] = 1'b1;
		end
	end

	// signed accumulation, copy to hours and clear on latch
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int t = 0; t < 5; t++)
				for (int ph = 0; ph < 3; ph++)
				begin
					energy_acc_reg[t][ph] <= '0;
					energy_hours[t][ph] <= '0;
				end
		end
		else
		begin
			for (int t = 0; t < 5; t++)
				for (int ph = 0; ph < 3; ph++)
				begin
					// all three phases, whatever the inclusion bits
					if (type_latch[t])
					begin
						energy_hours[t][ph] <= energy_acc_reg[t][ph];
						energy_acc_reg[t][ph] <= '0;
					end
					else if (tick)
						energy_acc_reg[t][ph] <= energy_acc_reg[t][ph]
							+ ENE_W'(phase_power[t][ph]);
				end
		end
	end

	// ****************************************************************
	// status, polarity flags and interrupt
	// ****************************************************************
	logic [31:0] status_set; // events this cycle, already masked

	// pulse events land on bits 16 to 14, sign changes on bits 18, 13 and 9
	// every other status position stays clear, whatever the mask holds
	// masked events are dropped here, so a later unmask shows no stale event
	// the host sees an event only through its sticky bit and the line

	// gather masked events into status positions
	always_comb
	begin
		status_set = '0;
		status_set[CF_IRQ_LSB +: 3] = ch_edge;
		status_set[REV1_BIT] = ch_change[0];
		status_set[REV2_BIT] = ch_change[1];
		status_set[REV3_BIT] = ch_change[2];
		status_set = status_set & irq_mask_primary;
	end

	// sticky status, set wins over a write-one clear
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			irq_status_primary <= STATUS_RST;
		else if (status_clear_wr)
			irq_status_primary <= (irq_status_primary & ~status_clear_data)
				| status_set;
		else
			irq_status_primary <= irq_status_primary | status_set;
	end

	// polarity flags move with the sign change status
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
			power_sign_flags <= SIGN_RST;
		else
		begin
			if (ch_change[0])
				power_sign_flags[SGN1_BIT] <= ch_neg[0];
			if (ch_change[1])
				power_sign_flags[SGN2_BIT] <= ch_neg[1];
			if (ch_change[2])
				power_sign_flags[SGN3_BIT] <= ch_neg[2];
		end
	end

	// active low while any enabled status bit stands
	assign interrupt_line_primary = ~|(irq_status_primary & irq_mask_primary);
endmodule : epel_top

// *** verification/epel_monitor.sv ***
// checker for the pulse event latch ports
`timescale 1ns/10ps
module epel_monitor
	import epel_pkg::*;
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [15:0] pulse_output_mode_reg,
	input wire logic [31:0] irq_mask_primary,
	input wire logic status_clear_wr,
	input wire logic [31:0] status_clear_data,
	input wire logic [31:0] irq_status_primary,
	input wire logic [15:0] power_sign_flags,
	input wire logic interrupt_line_primary,
	input wire logic pulse_out_one
);
	// ****************
	// port properties
	// ****************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// four low cycles, then high again
	sequence s_low4;
		(!pulse_out_one) [*4] ##1 pulse_out_one;
	endsequence
	// a one written to the pulse status bit, no new pulse behind it
	sequence s_clr14;
		status_clear_wr && status_clear_data[CF_IRQ_LSB] && !pulse_output_mode_reg[DIS_LSB]
			##1 !$fell(pulse_out_one);
	endsequence
	a_pulse_width: assert property ($fell(pulse_out_one) |-> s_low4)
		else $error("pulse low time wrong");
	a_pin_disabled: assert property (pulse_output_mode_reg[DIS_LSB] |-> pulse_out_one)
		else $error("disabled pin not high");
	a_pulse_status: assert property (
		$fell(pulse_out_one) && irq_mask_primary[CF_IRQ_LSB] |-> irq_status_primary[CF_IRQ_LSB])
		else $error("pulse status not set");
	a_irq_low: assert property (|(irq_status_primary & irq_mask_primary) |-> !interrupt_line_primary)
		else $error("interrupt not low");
	a_irq_high: assert property (!(|(irq_status_primary & irq_mask_primary)) |-> interrupt_line_primary)
		else $error("interrupt low with nothing pending");
	a_keep_unwritten: assert property (
		status_clear_wr && !status_clear_data[CF_IRQ_LSB] && irq_status_primary[CF_IRQ_LSB]
		|=> irq_status_primary[CF_IRQ_LSB]) else $error("unwritten bit cleared");
	a_w1c_clear: assert property (s_clr14 |-> !irq_status_primary[CF_IRQ_LSB])
		else $error("written bit not cleared");
	a_rev_on_fall: assert property (
		$rose(irq_status_primary[REV1_BIT]) && !pulse_output_mode_reg[DIS_LSB] |-> $fell(pulse_out_one))
		else $error("sign status off the edge");
	a_flag_with_rev: assert property (
		$changed(power_sign_flags[SGN1_BIT]) && irq_mask_primary[REV1_BIT] |-> irq_status_primary[REV1_BIT])
		else $error("flag without status");
endmodule : epel_monitor
bind epel_top epel_monitor u_epel_monitor (.sys_clk(sys_clk), .resetn(resetn),
	.pulse_output_mode_reg(pulse_output_mode_reg), .irq_mask_primary(irq_mask_primary),
	.status_clear_wr(status_clear_wr), .status_clear_data(status_clear_data),
	.irq_status_primary(irq_status_primary), .power_sign_flags(power_sign_flags),
	.interrupt_line_primary(interrupt_line_primary), .pulse_out_one(pulse_out_one));

// *** verification/epel_host_model.sv ***
// host model servicing the primary interrupt
`timescale 1ns/10ps
module epel_host_model
(
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [3:0] resp_delay,
	input wire logic interrupt_line_primary,
	input wire logic [31:0] irq_status_primary,
	input wire logic [15:0] power_sign_flags,
	output logic status_clear_wr,
	output logic [31:0] status_clear_data,
	output logic [31:0] seen_status
);
	logic [3:0] wait_cnt; // delay before the status read
	logic rd_done; // status read, flags next
	logic [15:0] last_flags; // polarity flags as read
	// read status, then flags, then write a one to the lowest pending bit
	always_ff @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			{status_clear_wr, rd_done, wait_cnt, last_flags} <= '0;
			{status_clear_data, seen_status} <= '0;
		end
		else
		begin
			status_clear_wr <= 1'b0;
			if (interrupt_line_primary || status_clear_wr)
			begin
				wait_cnt <= resp_delay;
				rd_done <= 1'b0;
			end
			else if (wait_cnt != 4'h0)
				wait_cnt <= wait_cnt - 4'h1;
			else if (!rd_done)
			begin
				rd_done <= 1'b1;
				seen_status <= seen_status | irq_status_primary;
				status_clear_data <= irq_status_primary & (~irq_status_primary + 32'h1);
			end
			else
			begin
				last_flags <= power_sign_flags;
				status_clear_wr <= 1'b1;
			end
		end
	end
endmodule : epel_host_model

// *** verification/tb_top.sv ***
// self-checking bench for the pulse event latch
`timescale 1ns/10ps
module tb_top;
	import epel_pkg::*;
	// ****************
	// signals and cases
	// ****************
	typedef struct packed {logic [2:0] sel; logic [3:0] accm; logic signed [23:0] pa, pr; logic sgn, pls;} epel_row_t;
	logic sys_clk, resetn, status_clear_wr, interrupt_line_primary, pulse_out_one, pulse_out_two;
	logic pulse_out_three;
	logic signed [23:0] phase_power [5][3];
	logic signed [31:0] energy_hours [5][3];
	logic [31:0] thr, irq_mask_primary, status_clear_data, irq_status_primary, seen_status;
	logic [15:0] pulse_output_mode_reg, power_sign_flags;
	logic [7:0] accumulation_mode_reg, latch_pulse_count;
	logic [8:0] computation_mode_reg;
	logic [3:0] resp_delay;
	int failures = 0;
	int n_tests = 0;
	// select, modes, phase a powers, polarity, pulses
	epel_row_t rows [13] = '{
		'{3'h0, 4'h0, -24'sd1, 24'sd0, 1'b1, 1'b1}, '{3'h0, 4'h1, -24'sd1, 24'sd0, 1'b1, 1'b1},
		'{3'h0, 4'h2, -24'sd1, 24'sd0, 1'b1, 1'b1}, '{3'h0, 4'h3, -24'sd1, 24'sd0, 1'b0, 1'b1},
		'{3'h3, 4'h3, -24'sd1, 24'sd0, 1'b0, 1'b1}, '{3'h1, 4'h0, 24'sd0, -24'sd1, 1'b1, 1'b1},
		'{3'h1, 4'h4, 24'sd0, -24'sd1, 1'b1, 1'b1}, '{3'h1, 4'h8, -24'sd1, -24'sd1, 1'b0, 1'b1},
		'{3'h1, 4'h8, 24'sd1, -24'sd1, 1'b1, 1'b1}, '{3'h1, 4'hc, 24'sd0, -24'sd1, 1'b0, 1'b1},
		'{3'h4, 4'hc, 24'sd0, -24'sd1, 1'b0, 1'b1}, '{3'h2, 4'h0, 24'sd0, 24'sd0, 1'b0, 1'b1},
		'{3'h5, 4'h0, 24'sd0, 24'sd0, 1'b0, 1'b0}};
	epel_top u_epel_top (.sys_clk, .resetn, .phase_power, .active_energy_threshold(thr),
		.reactive_energy_threshold(thr), .apparent_energy_threshold(thr), .pulse_output_mode_reg,
		.accumulation_mode_reg, .computation_mode_reg, .irq_mask_primary, .latch_pulse_count,
		.status_clear_wr, .status_clear_data, .irq_status_primary, .power_sign_flags,
		.interrupt_line_primary, .pulse_out_one, .pulse_out_two, .pulse_out_three, .energy_hours);
	epel_host_model u_epel_host_model (.sys_clk, .resetn, .resp_delay, .interrupt_line_primary,
		.irq_status_primary, .power_sign_flags, .status_clear_wr, .status_clear_data, .seen_status);
	// 250 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// compare and count
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// counts, verdict and end of run
	task automatic finish_test;
		$display("comparisons %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test
	// wait for the falling edge of output two, which pulses every tick
	task automatic sync_tick;
		logic pv;
		int n;
		n = 0;
		pv = pulse_out_two;
		@(negedge sys_clk);
		while (!(pv === 1'b1 && pulse_out_two === 1'b0) && n < 600)
		begin
			pv = pulse_out_two;
			@(negedge sys_clk);
			n++;
		end
		check("tick sync", 1'b1, n < 600);
	endtask : sync_tick
	// watchdog
	initial
	begin
		#200000;
		failures++;
		finish_test();
	end
	// main sequence
	initial
	begin
		epel_row_t r;
		int nf;
		logic pv;
		logic signed [31:0] k3;
		resetn = 1'b0;
		thr = 32'h1;
		foreach (phase_power[t, p]) phase_power[t][p] = 24'sd1;
		pulse_output_mode_reg = 16'h0810; // pin three off, output two apparent
		accumulation_mode_reg = 8'h00;
		computation_mode_reg = 9'h079; // phase a only on outputs one and three
		irq_mask_primary = 32'h0005_4200;
		latch_pulse_count = 8'h01;
		resp_delay = 4'h0;
		repeat (3) @(negedge sys_clk);
		check("reset status", STATUS_RST, irq_status_primary);
		check("reset flags", SIGN_RST, power_sign_flags);
		check("reset pins", 4'hf, {interrupt_line_primary, pulse_out_one, pulse_out_two, pulse_out_three});
		check("reset hours", 32'h0, energy_hours[1][2]);
		repeat (2) @(negedge sys_clk);
		resetn = 1'b1;
		foreach (rows[i])
		begin
			r = rows[i];
			sync_tick();
			pulse_output_mode_reg[2:0] = r.sel;
			accumulation_mode_reg[3:0] = r.accm;
			for (int p = 0; p < 3; p++)
			begin
				phase_power[0][p] = p ? 24'sd3 : r.pa;
				phase_power[3][p] = p ? 24'sd3 : r.pa;
				phase_power[1][p] = p ? 24'sd3 : r.pr;
				phase_power[4][p] = p ? 24'sd3 : r.pr;
			end
			nf = 0;
			pv = pulse_out_one;
			repeat (520)
			begin
				@(negedge sys_clk);
				if (pv === 1'b1 && pulse_out_one === 1'b0)
					nf++;
				pv = pulse_out_one;
			end
			check("pulse count", r.pls ? 2 : 0, nf);
			check("sum polarity", r.sgn, power_sign_flags[SGN1_BIT]);
		end
		check("hours idle", 32'h0, energy_hours[0][0]);
		check("seen pulse status", 3'h5, seen_status[16:14]);
		check("seen sign status", 1'b1, seen_status[REV1_BIT]);
		check("masked status", 1'b0, irq_status_primary[15]);
		sync_tick();
		resp_delay = 4'h9;
		pulse_output_mode_reg = 16'h4a50; // latch on output three, reactive; pins one, three off
		phase_power[0][0] = 24'sd1; // output one keeps pulsing behind its disabled pin
		latch_pulse_count = 8'h03;
		for (int p = 0; p < 3; p++)
			phase_power[1][p] = 24'(5 + p);
		repeat (12) sync_tick();
		check("disabled pulse status", 1'b1, irq_status_primary[CF_IRQ_LSB]);
		check("pin one held", 1'b1, pulse_out_one);
		check("pin three held", 1'b1, pulse_out_three);
		k3 = energy_hours[1][0] / 5;
		check("latched", 1'b1, k3 > 0);
		check("hours b", 6 * k3, energy_hours[1][1]);
		check("hours c", 7 * k3, energy_hours[1][2]);
		check("other type", 32'h0, energy_hours[0][1]);
		latch_pulse_count = 8'h05;
		repeat (20) sync_tick();
		check("count step", 32'h2, energy_hours[1][0] / 5 - k3);
		// mid-run reset just after a pulse: status, hours and pins go back to rest
		sync_tick();
		resetn = 1'b0;
		@(negedge sys_clk);
		check("mid reset status", STATUS_RST, irq_status_primary);
		check("mid reset hours", 32'h0, energy_hours[1][0]);
		check("mid reset pins", 4'hf, {interrupt_line_primary, pulse_out_one, pulse_out_two, pulse_out_three});
		repeat (2) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (2) @(negedge sys_clk);
		check("after reset flags", SIGN_RST, power_sign_flags);
		check("after reset hours", 32'h0, energy_hours[1][1]);
		check("after reset status", STATUS_RST, irq_status_primary);
		finish_test();
	end
endmodule : tb_top
